// ==== hdl/timer_pkg.sv ====
// constants and carrier types for the dual timer/counter block
package timer_pkg;
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE    = 8'h89;
   localparam logic [7:0] ADDR_FIRST_LOW     = 8'h8a;
   localparam logic [7:0] ADDR_SECOND_LOW    = 8'h8b;
   localparam logic [7:0] ADDR_FIRST_HIGH    = 8'h8c;
   localparam logic [7:0] ADDR_SECOND_HIGH   = 8'h8d;
   localparam logic [7:0] CONTROL_RESET      = 8'h00;
   localparam logic [7:0] MODE_RESET         = 8'h00;
   localparam logic [7:0] COUNT_RESET        = 8'h00;
   // timer_control bit positions
   localparam int BIT_SECOND_OVF   = 7;
   localparam int BIT_SECOND_RUN   = 6;
   localparam int BIT_FIRST_OVF    = 5;
   localparam int BIT_FIRST_RUN    = 4;
   localparam int BIT_SECOND_IRQ   = 3;
   localparam int BIT_SECOND_TYPE  = 2;
   localparam int BIT_FIRST_IRQ    = 1;
   localparam int BIT_FIRST_TYPE   = 0;
   // timer_mode_control: each timer owns a nibble, second timer in the upper one
   localparam int MODE_NIBBLE      = 4;
   localparam int BIT_GATE         = 3;
   localparam int BIT_COUNTER_SEL  = 2;
   localparam int MODE_FIELD_LSB   = 0;
   // event inputs are looked at once per this many system clocks
   localparam int          SAMPLE_PERIOD = 12;
   localparam logic [3:0]  SAMPLE_LAST   = 4'(SAMPLE_PERIOD - 1);
   localparam logic [4:0]  PRESCALE_MASK = 5'h1f;

   typedef enum logic [1:0] {
      MODE_12BIT,
      MODE_16BIT,
      MODE_8BIT_RELOAD,
      MODE_SPLIT
   } timer_mode_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic gate;
      logic counter_sel;
      logic [1:0] mode;
   } timer_cfg_s;
endpackage : timer_pkg

// ==== hdl/timer_unit.sv ====
// one 16-bit timer/counter: count path, mode handling and overflow detect
`timescale 1ns/1ns
module timer_unit (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire timer_pkg::timer_cfg_s cfg,
   input  wire logic                  run,
   input  wire logic                  gate_pin,
   input  wire logic                  event_tick,
   input  wire logic                  low_wr,
   input  wire logic                  high_wr,
   input  wire logic [7:0]            wdata,
   output logic      [7:0]            count_low,
   output logic      [7:0]            count_high,
   output logic                       overflow
);
   logic [7:0] next_low;
   logic [7:0] next_high;
   logic       enable;
   logic       step;

   always_comb begin
      enable    = run & (~cfg.gate | gate_pin);          // [RULE15]
      step      = enable & (cfg.counter_sel ? event_tick : 1'b1);  // [RULE2] [RULE18] [RULE5]
      next_low  = count_low;
      next_high = count_high;
      overflow  = 1'b0;
      if (step) begin
         case (timer_pkg::timer_mode_e'(cfg.mode))        // [RULE17] [RULE1]
            timer_pkg::MODE_12BIT: begin
               // low five bits prescale the lower seven of the high byte; the spare top bits only hold
               if ((count_low & 8'(timer_pkg::PRESCALE_MASK)) == 8'(timer_pkg::PRESCALE_MASK)) begin
                  next_low  = count_low & ~8'(timer_pkg::PRESCALE_MASK);
                  next_high = {count_high[7], count_high[6:0] + 7'h01};
                  overflow  = (count_high[6:0] == 7'h7f);  // [RULE19]
               end else begin
                  next_low = count_low + 8'h01;
               end
            end
            timer_pkg::MODE_16BIT: begin
               next_low = count_low + 8'h01;
               if (count_low == 8'hff) begin
                  next_high = count_high + 8'h01;
                  overflow  = (count_high == 8'hff);       // [RULE19]
               end
            end
            timer_pkg::MODE_8BIT_RELOAD: begin
               if (count_low == 8'hff) begin
                  next_low = count_high;
                  overflow = 1'b1;                          // [RULE19]
               end else begin
                  next_low = count_low + 8'h01;
               end
            end
            timer_pkg::MODE_SPLIT: begin
               // simplified: low byte runs alone as 8-bit counter
               next_low = count_low + 8'h01;
               overflow = (count_low == 8'hff);
            end
            default: begin
               next_low = count_low;
            end
         endcase
      end
      // software write beats the count step in the same cycle
      if (low_wr) begin
         next_low = wdata;
      end
      if (high_wr) begin
         next_high = wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         count_low  <= timer_pkg::COUNT_RESET;
         count_high <= timer_pkg::COUNT_RESET;
      end else begin
         count_low  <= next_low;
         count_high <= next_high;
      end
   end
endmodule : timer_unit

// ==== hdl/dual_timer.sv ====
// two timer/counters with their control, mode and count registers on the sfr bus
`timescale 1ns/1ns
// Functional notes
// RULE1: two timers, each two 8-bit bytes, counting 8, 12 or 16 bits per mode.
// RULE2: each timer counts clocks or events; four operating modes.
// RULE3: event inputs sampled once every twelve system clocks.
// RULE4: count when two successive samples go from high to low.
// RULE5: increment depends only on the falling transition, not duty cycle.
// RULE6: six registers: control, mode and four count bytes.
// RULE7: control bit 7 second timer overflow, cleared on service entry.
// RULE8: control bit 6 runs the second timer, subject to gating.
// RULE9: control bit 5 first timer overflow, cleared on service entry.
// RULE10: control bit 4 runs the first timer.
// RULE11: control bit 3 second external interrupt pending, cleared on entry; in level mode the flag follows the pin and the acknowledge is ignored.
// RULE12: control bit 2 second external interrupt type: 1 falling edge, 0 low level.
// RULE13: control bit 1 first external interrupt pending, cleared on entry; in level mode the flag follows the pin and the acknowledge is ignored.
// RULE14: control bit 0 first external interrupt type: 1 falling edge, 0 low level.
// RULE15: mode gate bit: with run set, count only while the irq pin is high.
// RULE16: control and mode registers reset to zero.
// RULE17: mode field 0 12-bit, 1 16-bit, 2 8-bit reload, 3 split.
// RULE18: counter-select bit makes a timer count external transitions.
// RULE19: overflow of the active count sets that timer's overflow flag.
// RULE20: per-source acknowledge pulse clears the matching flag; the external flags in level mode ignore it and follow the pin.
// RULE21: a software write to a flag beats a same-cycle hardware change.
module dual_timer (
   input  wire logic                  mclk,
   input  wire logic                  reset_n,
   input  wire timer_pkg::sfr_req_s   sfr_req,
   output logic      [7:0]            sfr_rdata,
   output logic                       sfr_hit,
   input  wire logic                  first_count_input,
   input  wire logic                  second_count_input,
   input  wire logic                  first_ext_irq_pin,
   input  wire logic                  second_ext_irq_pin,
   input  wire logic                  first_timer_ack,
   input  wire logic                  second_timer_ack,
   input  wire logic                  first_ext_irq_ack,
   input  wire logic                  second_ext_irq_ack,
   output logic                       first_timer_irq,
   output logic                       second_timer_irq,
   output logic                       first_ext_irq,
   output logic                       second_ext_irq
);
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
      addr_is = (a == target);
   endfunction : addr_is

   // pin synchronisers: stage one is read only by stage two
   logic [1:0] count_meta;
   logic [1:0] count_sync;
   logic [1:0] irq_meta;
   logic [1:0] irq_sync;
   logic [1:0] irq_prev;
   logic [1:0] count_sample;
   logic [1:0] count_sample_prev;
   logic [1:0] next_count_sample;
   logic [1:0] next_count_sample_prev;
   logic [3:0] prescale;
   logic [3:0] next_prescale;
   logic       sample_now;
   logic [1:0] event_tick;

   logic [7:0] timer_control;
   logic [7:0] timer_mode_control;
   logic [7:0] next_control;
   logic [7:0] next_mode;
   logic [1:0] overflow;
   logic [1:0] fall;
   logic [7:0] count_low  [2];
   logic [7:0] count_high [2];
   logic [7:0] next_rdata;
   logic       next_hit;

   logic       ctrl_wr;
   logic       mode_wr;
   logic [1:0] low_wr;
   logic [1:0] high_wr;
   logic [1:0] run;
   logic [1:0] type_edge;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         count_meta <= 2'h0;
         count_sync <= 2'h0;
         irq_meta   <= 2'h3;
         irq_sync   <= 2'h3;
         irq_prev   <= 2'h3;
      end else begin
         count_meta <= {second_count_input, first_count_input};
         count_sync <= count_meta;
         irq_meta   <= {second_ext_irq_pin, first_ext_irq_pin};
         irq_sync   <= irq_meta;
         irq_prev   <= irq_sync;
      end
   end

   always_comb begin
      sample_now             = (prescale == timer_pkg::SAMPLE_LAST);
      next_prescale          = sample_now ? 4'h0 : prescale + 4'h1;   // [RULE3]
      next_count_sample      = sample_now ? count_sync : count_sample;
      next_count_sample_prev = sample_now ? count_sample : count_sample_prev;
      // one tick per high-to-low pair of samples, regardless of pulse width
      event_tick             = count_sample_prev & ~count_sample & {2{sample_now}};  // [RULE4] [RULE5]
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         prescale          <= 4'h0;
         count_sample      <= 2'h0;
         count_sample_prev <= 2'h0;
      end else begin
         prescale          <= next_prescale;
         count_sample      <= next_count_sample;
         count_sample_prev <= next_count_sample_prev;
      end
   end

   always_comb begin
      ctrl_wr    = sfr_req.wr & addr_is(sfr_req.addr, timer_pkg::ADDR_TIMER_CONTROL);
      mode_wr    = sfr_req.wr & addr_is(sfr_req.addr, timer_pkg::ADDR_TIMER_MODE);
      low_wr[0]  = sfr_req.wr & addr_is(sfr_req.addr, timer_pkg::ADDR_FIRST_LOW);   // [RULE6]
      low_wr[1]  = sfr_req.wr & addr_is(sfr_req.addr, timer_pkg::ADDR_SECOND_LOW);
      high_wr[0] = sfr_req.wr & addr_is(sfr_req.addr, timer_pkg::ADDR_FIRST_HIGH);
      high_wr[1] = sfr_req.wr & addr_is(sfr_req.addr, timer_pkg::ADDR_SECOND_HIGH);
      run[0]     = timer_control[timer_pkg::BIT_FIRST_RUN];                   // [RULE10]
      run[1]     = timer_control[timer_pkg::BIT_SECOND_RUN];                  // [RULE8]
      type_edge[0] = timer_control[timer_pkg::BIT_FIRST_TYPE];
      type_edge[1] = timer_control[timer_pkg::BIT_SECOND_TYPE];
      fall       = irq_prev & ~irq_sync;
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_unit
         timer_unit u_timer (
            .mclk       (mclk),
            .reset_n    (reset_n),
            .cfg        (timer_pkg::timer_cfg_s'(timer_mode_control[g*timer_pkg::MODE_NIBBLE +: 4])),
            .run        (run[g]),
            .gate_pin   (irq_sync[g]),
            .event_tick (event_tick[g]),
            .low_wr     (low_wr[g]),
            .high_wr    (high_wr[g]),
            .wdata      (sfr_req.wdata),
            .count_low  (count_low[g]),
            .count_high (count_high[g]),
            .overflow   (overflow[g])
         );
      end
   endgenerate

   always_comb begin
      next_control = timer_control;
      next_mode    = mode_wr ? sfr_req.wdata : timer_mode_control;
      // hardware sets win over acknowledges; software writes win over both
      if (first_timer_ack)  next_control[timer_pkg::BIT_FIRST_OVF]  = 1'b0;   // [RULE9] [RULE20]
      if (second_timer_ack) next_control[timer_pkg::BIT_SECOND_OVF] = 1'b0;   // [RULE7] [RULE20]
      if (overflow[0])      next_control[timer_pkg::BIT_FIRST_OVF]  = 1'b1;   // [RULE19]
      if (overflow[1])      next_control[timer_pkg::BIT_SECOND_OVF] = 1'b1;   // [RULE19]
      // edge mode latches a falling edge; level mode follows the pin low
      if (type_edge[0]) begin                                                 // [RULE14] [RULE13]
         if (first_ext_irq_ack) next_control[timer_pkg::BIT_FIRST_IRQ] = 1'b0;  // [RULE20]
         if (fall[0])           next_control[timer_pkg::BIT_FIRST_IRQ] = 1'b1;
      end else begin
         next_control[timer_pkg::BIT_FIRST_IRQ] = ~irq_sync[0];
      end
      if (type_edge[1]) begin                                                 // [RULE12] [RULE11]
         if (second_ext_irq_ack) next_control[timer_pkg::BIT_SECOND_IRQ] = 1'b0;  // [RULE20]
         if (fall[1])            next_control[timer_pkg::BIT_SECOND_IRQ] = 1'b1;
      end else begin
         next_control[timer_pkg::BIT_SECOND_IRQ] = ~irq_sync[1];
      end
      if (ctrl_wr) begin
         next_control = sfr_req.wdata;                                        // [RULE21]
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         timer_control      <= timer_pkg::CONTROL_RESET;                      // [RULE16]
         timer_mode_control <= timer_pkg::MODE_RESET;                         // [RULE16]
      end else begin
         timer_control      <= next_control;
         timer_mode_control <= next_mode;
      end
   end

   always_comb begin
      next_hit   = sfr_req.rd;
      next_rdata = 8'h00;
      case (sfr_req.addr)
         timer_pkg::ADDR_TIMER_CONTROL: next_rdata = timer_control;
         timer_pkg::ADDR_TIMER_MODE:    next_rdata = timer_mode_control;
         timer_pkg::ADDR_FIRST_LOW:     next_rdata = count_low[0];
         timer_pkg::ADDR_SECOND_LOW:    next_rdata = count_low[1];
         timer_pkg::ADDR_FIRST_HIGH:    next_rdata = count_high[0];
         timer_pkg::ADDR_SECOND_HIGH:   next_rdata = count_high[1];
         default: begin
            next_hit   = 1'b0;
            next_rdata = 8'h00;
         end
      endcase
      if (!sfr_req.rd) begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sfr_rdata        <= 8'h00;
         sfr_hit          <= 1'b0;
         first_timer_irq  <= 1'b0;
         second_timer_irq <= 1'b0;
         first_ext_irq    <= 1'b0;
         second_ext_irq   <= 1'b0;
      end else begin
         sfr_rdata        <= next_rdata;
         sfr_hit          <= next_hit;
         first_timer_irq  <= next_control[timer_pkg::BIT_FIRST_OVF];
         second_timer_irq <= next_control[timer_pkg::BIT_SECOND_OVF];
         first_ext_irq    <= next_control[timer_pkg::BIT_FIRST_IRQ];
         second_ext_irq   <= next_control[timer_pkg::BIT_SECOND_IRQ];
      end
   end
endmodule : dual_timer

// ==== dv/irq_ack_model.sv ====
// interrupt logic stand-in: acknowledges enabled pending sources after a delay
`timescale 1ns/1ns
module irq_ack_model (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic [3:0] irq,
   input  wire logic [3:0] enable,
   input  wire logic [7:0] delay,
   output logic      [3:0] ack
);
   logic [7:0] wait_cnt;
   logic [7:0] next_wait_cnt;
   logic [3:0] next_ack;
   always_comb begin
      next_ack      = 4'h0;
      next_wait_cnt = 8'h00;
      // ~ack stops a flag that is still clearing from being acknowledged twice
      if (|(irq & enable & ~ack)) begin
         next_wait_cnt = wait_cnt + 8'h01;
         if (wait_cnt >= delay) begin
            next_ack      = irq & enable;
            next_wait_cnt = 8'h00;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wait_cnt <= 8'h00;
         ack      <= 4'h0;
      end else begin
         wait_cnt <= next_wait_cnt;
         ack      <= next_ack;
      end
   end
endmodule : irq_ack_model

// ==== dv/dual_timer_chk.sv ====
// port assertions for the dual timer block
`timescale 1ns/1ns
module dual_timer_chk (
   input wire logic                mclk,
   input wire logic                reset_n,
   input wire timer_pkg::sfr_req_s sfr_req,
   input wire logic [7:0]          sfr_rdata,
   input wire logic                sfr_hit,
   input wire logic                first_ext_irq_pin,
   input wire logic                second_ext_irq_pin,
   input wire logic                first_timer_ack,
   input wire logic                second_ext_irq_ack,
   input wire logic                first_timer_irq,
   input wire logic                second_timer_irq,
   input wire logic                first_ext_irq,
   input wire logic                second_ext_irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic       type0;
   logic       type1;
   wire logic  ctl_wr = sfr_req.wr && sfr_req.addr == timer_pkg::ADDR_TIMER_CONTROL;
   wire logic  mapped = sfr_req.addr >= timer_pkg::ADDR_TIMER_CONTROL && sfr_req.addr <= timer_pkg::ADDR_SECOND_HIGH;
   wire logic [7:0] flags = {second_timer_irq, 1'b0, first_timer_irq, 1'b0, second_ext_irq, 1'b0, first_ext_irq, 1'b0};
   // type bits move only by software writes, so watching the bus is enough
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         type0 <= 1'b0;
         type1 <= 1'b0;
      end else if (ctl_wr) begin
         type0 <= sfr_req.wdata[timer_pkg::BIT_FIRST_TYPE];
         type1 <= sfr_req.wdata[timer_pkg::BIT_SECOND_TYPE];
      end
   end
   sequence s_edge_fall; type1 && $fell(second_ext_irq_pin); endsequence
   sequence s_edge_seen; ##[1:5] (second_ext_irq || ctl_wr); endsequence
   sequence s_level_steady; (!type0 && !ctl_wr && $stable(first_ext_irq_pin))[*5]; endsequence
   a_read_mapped: assert property (sfr_req.rd && mapped |=> sfr_hit)
      else $error("no hit after mapped read");
   a_read_unmapped: assert property (sfr_req.rd && !mapped |=> !sfr_hit && sfr_rdata == 8'h00)
      else $error("unmapped read answered");
   a_bus_idle_quiet: assert property (!sfr_req.rd |=> !sfr_hit && sfr_rdata == 8'h00)
      else $error("read answer without read");
   a_ctl_write_wins: assert property (ctl_wr |=> flags == ($past(sfr_req.wdata) & 8'haa))
      else $error("flag outputs differ from written control");
   a_ovf_flag_holds: assert property (first_timer_irq && !first_timer_ack && !ctl_wr |=> first_timer_irq)
      else $error("overflow flag lost without ack");
   a_edge_flag_holds: assert property (type1 && second_ext_irq && !second_ext_irq_ack && !ctl_wr |=> second_ext_irq)
      else $error("edge flag lost without ack");
   a_edge_sets_flag: assert property (s_edge_fall |-> s_edge_seen)
      else $error("falling edge not flagged");
   a_level_follows_pin: assert property (s_level_steady |-> first_ext_irq == !first_ext_irq_pin)
      else $error("level pending differs from pin");
endmodule : dual_timer_chk
bind dual_timer dual_timer_chk u_chk (.mclk, .reset_n, .sfr_req, .sfr_rdata, .sfr_hit, .first_ext_irq_pin,
   .second_ext_irq_pin, .first_timer_ack, .second_ext_irq_ack, .first_timer_irq, .second_timer_irq,
   .first_ext_irq, .second_ext_irq);

// ==== dv/dual_timer_tb.sv ====
// self-checking bench for the dual timer block
`timescale 1ns/1ns
module dual_timer_tb;
   logic                mclk;
   logic                reset_n;
   timer_pkg::sfr_req_s sfr_req;
   logic [7:0]          sfr_rdata;
   logic                sfr_hit;
   logic [1:0]          cnt_pin;
   logic [1:0]          ext_pin;
   logic [3:0]          ack;
   logic [3:0]          irq;
   logic [3:0]          ack_en;
   logic [7:0]          ack_delay;
   logic [7:0]          rd_val;
   logic                rd_hit;
   logic [27:0]         rows [7];
   int                  n_errors;
   int                  comparisons;
   int                  cycles;
   dual_timer DUT (.mclk(mclk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .first_count_input(cnt_pin[0]), .second_count_input(cnt_pin[1]), .first_ext_irq_pin(ext_pin[0]),
      .second_ext_irq_pin(ext_pin[1]), .first_timer_ack(ack[0]), .second_timer_ack(ack[1]),
      .first_ext_irq_ack(ack[2]), .second_ext_irq_ack(ack[3]), .first_timer_irq(irq[0]),
      .second_timer_irq(irq[1]), .first_ext_irq(irq[2]), .second_ext_irq(irq[3]));
   irq_ack_model u_cpu (.mclk(mclk), .reset_n(reset_n), .irq(irq), .enable(ack_en), .delay(ack_delay), .ack(ack));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic stop_test();
      if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   // one-cycle request; the answer is registered, so it is read one ns after the taking edge
   task automatic sfr(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      cyc(1);
      sfr_req = '{wr, !wr, addr, data};
      cyc(1);
      sfr_req = '0;
      rd_val = sfr_rdata;
      rd_hit = sfr_hit;
   endtask : sfr
   task automatic wait_irq(input int idx, input logic val, input int max);
      for (int i = 0; i < max && irq[idx] !== val; i++) cyc(1);
      chk({7'h00, irq[idx]}, {7'h00, val});
   endtask : wait_irq
   initial begin
      sfr_req = '0;
      reset_n = 1'b0;
      cnt_pin = 2'b00;
      ext_pin = 2'b11;
      ack_en = 4'h0;
      ack_delay = 8'h00;
      n_errors = 0;
      comparisons = 0;
      cycles = 0;
      rows = '{28'h89_5a_5a_1, 28'h8a_3c_3c_1, 28'h8b_c3_c3_1, 28'h8c_a5_a5_1, 28'h8d_5a_5a_1,
               28'h87_ff_00_0, 28'h88_05_05_1};
      cyc(10);
      reset_n = 1'b1;
      chk({4'h0, irq}, 8'h00);
      for (logic [7:0] a = timer_pkg::ADDR_TIMER_CONTROL; a <= timer_pkg::ADDR_SECOND_HIGH; a++) begin
         sfr(1'b0, a, 8'h00);
         chk(rd_val, (a == timer_pkg::ADDR_TIMER_CONTROL) ? timer_pkg::CONTROL_RESET :
             ((a == timer_pkg::ADDR_TIMER_MODE) ? timer_pkg::MODE_RESET : timer_pkg::COUNT_RESET));
      end
      foreach (rows[r]) begin
         sfr(1'b1, rows[r][27:20], rows[r][19:12]);
         sfr(1'b0, rows[r][27:20], 8'h00);
         chk(rd_val, rows[r][11:4]);
         chk({7'h00, rd_hit}, {4'h0, rows[r][3:0]});
      end
      // every mode on both timers, from a preset just short of overflow
      for (int t = 0; t < 2; t++) begin
         for (int m = 0; m < 4; m++) begin
            sfr(1'b1, timer_pkg::ADDR_TIMER_MODE, 8'(m << (4 * t)));
            sfr(1'b1, 8'(timer_pkg::ADDR_FIRST_LOW + t), (m == 0) ? 8'h1f : ((m == 1) ? 8'hfe : 8'hff));
            sfr(1'b1, 8'(timer_pkg::ADDR_FIRST_HIGH + t), (m == 2) ? 8'hab : ((m == 0) ? 8'h7f : 8'hff));
            sfr(1'b1, timer_pkg::ADDR_TIMER_CONTROL, 8'h10 << (2 * t));
            wait_irq(t, 1'b1, 8);
            sfr(1'b1, timer_pkg::ADDR_TIMER_CONTROL, 8'h20 << (2 * t));
            sfr(1'b0, 8'(timer_pkg::ADDR_FIRST_HIGH + t), 8'h00);
            if (m != 3) chk(rd_val, (m == 2) ? 8'hab : 8'h00);
            ack_delay = 8'(5 * m);
            ack_en = 4'(1 << t);
            wait_irq(t, 1'b0, 30);
            ack_en = 4'h0;
         end
      end
      sfr(1'b1, timer_pkg::ADDR_TIMER_MODE, 8'h90);
      sfr(1'b1, timer_pkg::ADDR_SECOND_LOW, 8'h00);
      ext_pin[1] = 1'b0;
      sfr(1'b1, timer_pkg::ADDR_TIMER_CONTROL, 8'h40);
      cyc(20);
      chk({7'h00, irq[3]}, 8'h01);
      sfr(1'b0, timer_pkg::ADDR_SECOND_LOW, 8'h00);
      chk(rd_val, 8'h00);
      ext_pin[1] = 1'b1;
      cyc(20);
      sfr(1'b0, timer_pkg::ADDR_SECOND_LOW, 8'h00);
      chk({7'h00, rd_val != 8'h00}, 8'h01);
      chk({7'h00, irq[3]}, 8'h00);
      // both counters see three falls, with high and low phases of unequal length
      sfr(1'b1, timer_pkg::ADDR_TIMER_MODE, 8'h55);
      sfr(1'b1, timer_pkg::ADDR_FIRST_LOW, 8'h00);
      sfr(1'b1, timer_pkg::ADDR_SECOND_LOW, 8'h00);
      sfr(1'b1, timer_pkg::ADDR_TIMER_CONTROL, 8'h50);
      for (int e = 0; e < 3; e++) begin
         cnt_pin = 2'b11;
         cyc(13 + 20 * e);
         cnt_pin = 2'b00;
         cyc(37 - 10 * e);
      end
      cyc(30);
      for (int t = 0; t < 2; t++) begin
         sfr(1'b0, 8'(timer_pkg::ADDR_FIRST_LOW + t), 8'h00);
         chk(rd_val, 8'h03);
      end
      sfr(1'b1, timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
      for (int i = 0; i < 2; i++) begin
         ext_pin[i] = 1'b0;
         ack_en = 4'(4 << i);
         cyc(10);
         chk({7'h00, irq[2 + i]}, 8'h01);
         ext_pin[i] = 1'b1;
         cyc(6);
         chk({7'h00, irq[2 + i]}, 8'h00);
         ack_en = 4'h0;
         sfr(1'b1, timer_pkg::ADDR_TIMER_CONTROL, 8'(1 << (2 * i)));
         ext_pin[i] = 1'b0;
         cyc(6);
         ext_pin[i] = 1'b1;
         cyc(6);
         chk({7'h00, irq[2 + i]}, 8'h01);
         ack_en = 4'(4 << i);
         wait_irq(2 + i, 1'b0, 20);
         ack_en = 4'h0;
         sfr(1'b1, timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
      end
      stop_test();
   end
endmodule : dual_timer_tb
